// ---- rtl/pwm_out_channel.sv ----
// Purpose: One PWM output flip-flop driven by set and clear events
// Assumes: Events are single-cycle pulses on the counter tick
// Notes:   Clear beats set, so equal edges give a low output
`timescale 1ns/100ps
module pwm_out_channel
   import pwm_timer_pkg::*;
(
   input  wire logic clk_sys,   // System clock
   input  wire logic rst_b,     // Async reset, active low
   input  wire logic enable,    // Output enabled, else constant low
   input  wire logic set_evt,   // Rising edge event
   input  wire logic clr_evt,   // Falling edge event
   output logic      pwm_ff     // Registered output level
);

   // Level follows the latest event; clear wins when both arrive together
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pwm_ff <= 1'b0;
      end else if (!enable || clr_evt) begin
         pwm_ff <= 1'b0;
      end else if (set_evt) begin
         pwm_ff <= 1'b1;
      end
   end

endmodule

// ---- rtl/pwm_prescaler.sv ----
// Purpose: Programmable prescaler producing the counter tick
// Assumes: Single clock domain, terminal value from a register
// Notes:   Tick is combinational so the counter steps in the same cycle
`timescale 1ns/100ps
module pwm_prescaler
   import pwm_timer_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic         clk_sys,   // System clock
   input  wire logic         rst_b,     // Async reset, active low
   input  wire logic         enable,    // Count allowed
   input  wire logic         clear,     // Hold at zero
   input  wire logic [W-1:0] terminal,  // Last count before tick
   output logic              tick,      // One-cycle counter step
   output logic      [W-1:0] count      // Current prescale count
);

   logic [W-1:0] psc_ff;

   assign count = psc_ff;
   assign tick  = enable && !clear && (psc_ff == terminal);

   // Restart from zero after the terminal value
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         psc_ff <= '0;
      end else if (clear || tick) begin
         psc_ff <= '0;
      end else if (enable) begin
         psc_ff <= psc_ff + 1'b1;
      end
   end

endmodule

// ---- rtl/pwm_timer.sv ----
// Purpose: Multi-output PWM timer with seven match registers
// Assumes: Classic Wishbone, one 40 MHz clock, async active-low reset
// Notes:   Output n in double-edge mode rises on match n-1, falls on match n
`timescale 1ns/100ps
`include "pwm_timer_consts.svh"

// Functional notes
// - Count clears on cycle match equality
// - Single-edge outputs rise at cycle, fall on own
// - Double-edge outputs use rise and fall matches
// - Double-edge edges anywhere inside the cycle
// - Seven matches serve six outputs, mixed
// - Match acts: continue, stop, reset, interrupt
// - Period and width in whole ticks, shared
// - 32-bit counter behind 32-bit prescaler
// - PWM outputs, the level interrupt and the bus replies leave the block
module pwm_timer
   import pwm_timer_pkg::*;
(
   input  wire logic        clk_sys,     // System clock, 40 MHz
   input  wire logic        rst_b,       // Async reset, active low
   input  wire logic        wb_cyc_i,    // Bus cycle
   input  wire logic        wb_stb_i,    // Strobe
   input  wire logic        wb_we_i,     // Write enable
   input  wire logic [7:0]  wb_adr_i,    // Byte address
   input  wire logic [3:0]  wb_sel_i,    // Byte lanes
   input  wire logic [31:0] wb_dat_i,    // Write data
   output logic      [31:0] wb_dat_o,    // Read data
   output logic             wb_ack_o,    // Acknowledge
   output logic             irq_o,       // Level interrupt
   output logic [`NUM_OUT:1] pwm_o       // PWM outputs
);

   wb_req_type               req;
   logic                     access;
   logic                     ack_ff;
   word_type                 rdat_ff;
   word_type                 nxt_rdat;
   logic                     run_ff;
   logic                     hold_ff;
   logic [`CNT_W-1:0]        tc_ff;
   logic [`CNT_W-1:0]        psc_term_ff;
   logic [`CNT_W-1:0]        psc_cnt;
   logic [`MCR_W-1:0]        mcr_ff;
   logic [15:0]              ocr_ff;
   logic [`NUM_MATCH-1:0]    status_ff;
   logic [`NUM_MATCH-1:0]    nxt_status;
   logic [`NUM_MATCH-1:0]    mask_ff;
   logic                     irq_ff;
   logic [`CNT_W-1:0]        match_ff [`NUM_MATCH];
   logic [`NUM_MATCH-1:0]    hit;
   logic [`NUM_MATCH-1:0]    ev;
   logic [`NUM_MATCH-1:0]    ev_int;
   logic [`NUM_MATCH-1:0]    ev_rst;
   logic [`NUM_MATCH-1:0]    ev_stop;
   logic                     tick;
   logic                     cnt_rst;
   logic                     stop_evt;
   logic [`NUM_OUT:1]        out_en;
   logic [`NUM_OUT:1]        out_dbl;

   // Merge byte lanes of a write into the old word
   function automatic word_type merge(input word_type old, input word_type dat,
                                      input logic [3:0] sel);
      word_type res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Bus request capture; one access per ack, ack drops the next cycle
   assign req    = '{we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
   assign access = wb_cyc_i && wb_stb_i && !ack_ff;

   function automatic logic wr_at(input wb_req_type r, input logic acc,
                                  input logic [7:0] ofs);
      return acc && r.we && (r.adr[7:2] == ofs[7:2]);
   endfunction

   // Counter step and match action decode
   pwm_prescaler #(.W(`CNT_W)) u_psc (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .enable   (run_ff),
      .clear    (hold_ff),
      .terminal (psc_term_ff),
      .tick     (tick),
      .count    (psc_cnt)
   );

   // Per match register: storage, comparison, action bits
   genvar gm;
   generate
      for (gm = 0; gm < `NUM_MATCH; gm++) begin : g_match
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               match_ff[gm] <= `RST_WORD;
            end else if (wr_at(req, access, 8'(`OFS_MATCH_BASE + 4*gm))) begin
               match_ff[gm] <= merge(match_ff[gm], req.dat, req.sel);
            end
         end
         assign hit[gm]     = (tc_ff == match_ff[gm]);
         assign ev[gm]      = tick && hit[gm];
         assign ev_int[gm]  = ev[gm] && mcr_ff[`MCR_STRIDE*gm + `MCR_INT_BIT];
         assign ev_rst[gm]  = ev[gm] && mcr_ff[`MCR_STRIDE*gm + `MCR_RST_BIT];
         assign ev_stop[gm] = ev[gm] && mcr_ff[`MCR_STRIDE*gm + `MCR_STOP_BIT];
      end
   endgenerate

   // Cycle match always restarts the period; others only when asked
   assign cnt_rst  = ev[0] || (|ev_rst);
   assign stop_evt = |ev_stop;

   // Main 32-bit counter; software may load it directly
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tc_ff <= `RST_WORD;
      end else if (wr_at(req, access, `OFS_COUNT)) begin
         tc_ff <= merge(tc_ff, req.dat, req.sel);
      end else if (hold_ff) begin
         tc_ff <= '0;
      end else if (tick) begin
         tc_ff <= cnt_rst ? '0 : tc_ff + 1'b1;
      end
   end

   // Run and hold; a stop match wins over a software start
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {hold_ff, run_ff} <= `RST_CTRL;
      end else begin
         if (wr_at(req, access, `OFS_CTRL) && req.sel[0]) begin
            run_ff  <= req.dat[`CTRL_RUN_BIT];
            hold_ff <= req.dat[`CTRL_HOLD_BIT];
         end
         if (stop_evt) begin
            run_ff <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         psc_term_ff <= `RST_WORD;
         mcr_ff      <= '0;
         ocr_ff      <= '0;
         mask_ff     <= `RST_FLAGS;
      end else begin
         if (wr_at(req, access, `OFS_PSC_TERM)) begin
            psc_term_ff <= merge(psc_term_ff, req.dat, req.sel);
         end
         if (wr_at(req, access, `OFS_MATCH_CTRL)) begin
            mcr_ff <= `MCR_W'(merge(word_type'(mcr_ff), req.dat, req.sel));
         end
         if (wr_at(req, access, `OFS_OUT_CTRL)) begin
            ocr_ff <= 16'(merge(word_type'(ocr_ff), req.dat, req.sel));
         end
         if (wr_at(req, access, `OFS_MASK)) begin
            mask_ff <= `NUM_MATCH'(merge(word_type'(mask_ff), req.dat, req.sel));
         end
      end
   end

   // Sticky flags: read clears, but a new event in that cycle survives
   always_comb begin
      nxt_status = status_ff;
      if (access && !req.we && (req.adr[7:2] == `OFS_STATUS >> 2)) begin
         nxt_status = '0;
      end
      nxt_status = nxt_status | ev_int;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         status_ff <= `RST_FLAGS;
         irq_ff    <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         irq_ff    <= |(nxt_status & mask_ff);
      end
   end

   // Output channels, single or double edge per output
   assign out_en  = ocr_ff[`OCR_EN_LSB +: `NUM_OUT];
   assign out_dbl = ocr_ff[`OCR_DBL_LSB +: `NUM_OUT];

   genvar go;
   generate
      for (go = 1; go <= `NUM_OUT; go++) begin : g_out
         logic set_evt;
         // Output 1 has no free match before it, so it is single-edge only
         assign set_evt = (go > 1 && out_dbl[go]) ? ev[go-1] : ev[0];
         pwm_out_channel u_chan (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .enable  (out_en[go]),
            .set_evt (set_evt),
            .clr_evt (ev[go]),
            .pwm_ff  (pwm_o[go])
         );
      end
   endgenerate

   // Read data mux; unmapped words read zero
   always_comb begin
      nxt_rdat = '0;
      if (req.adr[7:2] >= (`OFS_MATCH_BASE >> 2) &&
          req.adr[7:2] <  6'((`OFS_MATCH_BASE >> 2) + `NUM_MATCH)) begin
         nxt_rdat = match_ff[3'(req.adr[7:2] - (`OFS_MATCH_BASE >> 2))];
      end else begin
         unique case ({req.adr[7:2], 2'b00})
            `OFS_CTRL:       nxt_rdat = 32'({hold_ff, run_ff});
            `OFS_STATUS:     nxt_rdat = 32'(status_ff);
            `OFS_MASK:       nxt_rdat = 32'(mask_ff);
            `OFS_COUNT:      nxt_rdat = tc_ff;
            `OFS_PSC_TERM:   nxt_rdat = psc_term_ff;
            `OFS_PSC_CNT:    nxt_rdat = psc_cnt;
            `OFS_MATCH_CTRL: nxt_rdat = 32'(mcr_ff);
            `OFS_OUT_CTRL:   nxt_rdat = 32'(ocr_ff);
            default:         nxt_rdat = '0;
         endcase
      end
   end

   // Single-wait-state answer keeps every bus output registered
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_ff  <= 1'b0;
         rdat_ff <= `RST_WORD;
      end else begin
         ack_ff <= access;
         if (access && !req.we) begin
            rdat_ff <= nxt_rdat;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign irq_o    = irq_ff;

   // Checks on counter, outputs and match actions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   property p_cycle_clear;
      (ev[0] && !hold_ff && !wr_at(req, access, `OFS_COUNT)) |=> (tc_ff == '0);
   endproperty
   a_cycle_clear: assert property (p_cycle_clear) else $error("count not cleared");

   property p_single_rise;
      (ev[0] && !ev[1] && out_en[1]) ##1 out_en[1] |-> pwm_o[1];
   endproperty
   a_single_rise: assert property (p_single_rise) else $error("no rise at cycle");

   property p_own_fall;
      ev[1] |=> !pwm_o[1];
   endproperty
   a_own_fall: assert property (p_own_fall) else $error("no fall on match");

   property p_dbl_rise;
      (ev[1] && !ev[2] && out_en[2] && out_dbl[2]) ##1 out_en[2] |-> pwm_o[2];
   endproperty
   a_dbl_rise: assert property (p_dbl_rise) else $error("double edge no rise");

   property p_dbl_hold;
      (out_en[2] && out_dbl[2] && !ev[1] && !ev[2]) ##1 out_en[2] |-> $stable(pwm_o[2]);
   endproperty
   a_dbl_hold: assert property (p_dbl_hold) else $error("edge off match");

   property p_off_low;
      !out_en[3] |=> !pwm_o[3];
   endproperty
   a_off_low: assert property (p_off_low) else $error("disabled output high");

   property p_stop;
      stop_evt |=> !run_ff ##1 !tick;
   endproperty
   a_stop: assert property (p_stop) else $error("stop match ignored");

   // Match 0 carries the interrupt in the bench, so this antecedent is reached
   property p_irq;
      (ev_int[0] && mask_ff[0]) |=> status_ff[0] && irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("match interrupt lost");

   property p_step;
      (tick && !cnt_rst && !hold_ff && !wr_at(req, access, `OFS_COUNT))
         |=> tc_ff == $past(tc_ff) + 32'h0000_0001;
   endproperty
   a_step: assert property (p_step) else $error("counter step wrong");

   property p_idle;
      (!tick && !hold_ff && !wr_at(req, access, `OFS_COUNT)) |=> $stable(tc_ff);
   endproperty
   a_idle: assert property (p_idle) else $error("count moved off tick");

   property p_psc_wrap;
      tick |=> psc_cnt == '0;
   endproperty
   a_psc_wrap: assert property (p_psc_wrap) else $error("prescaler no wrap");

   c_cycle:  cover property (ev[0] ##[1:40] ev[0]);
   c_neg:    cover property (out_dbl[2] && ev[2] ##[1:40] ev[1]);
   c_stop:   cover property (stop_evt);
   c_irq:    cover property ($rose(irq_o));

endmodule

// ---- rtl/pwm_timer_consts.svh ----
// Purpose: Offsets, field positions and reset values of the PWM timer
// Assumes: 32-bit classic Wishbone slave, word-aligned registers
// Notes:   Definitions only
`ifndef PWM_TIMER_CONSTS_SVH
`define PWM_TIMER_CONSTS_SVH

`define NUM_MATCH        7
`define NUM_OUT          6
`define CNT_W            32

// Register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_MASK         8'h08
`define OFS_COUNT        8'h0C
`define OFS_PSC_TERM     8'h10
`define OFS_PSC_CNT      8'h14
`define OFS_MATCH_CTRL   8'h18
`define OFS_OUT_CTRL     8'h1C
`define OFS_MATCH_BASE   8'h20

// Control fields
`define CTRL_RUN_BIT     0
`define CTRL_HOLD_BIT    1
// Match control: three bits per match register
`define MCR_STRIDE       3
`define MCR_INT_BIT      0
`define MCR_RST_BIT      1
`define MCR_STOP_BIT     2
`define MCR_W            21
// Output control: double-edge selects and enables
`define OCR_DBL_LSB      0
`define OCR_EN_LSB       8

`define RST_WORD         32'h0000_0000
`define RST_CTRL         2'h2
`define RST_FLAGS        7'h00

`endif

// ---- rtl/pwm_timer_pkg.sv ----
// Purpose: Shared types of the PWM timer
// Assumes: Constants come from pwm_timer_consts.svh
// Notes:   Bus request travels as one packed struct
package pwm_timer_pkg;

   // One classic Wishbone request as seen by the slave
   typedef struct packed {
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef logic [31:0] word_type;

endpackage

// ---- testbench/multi_output_pwm_timer_test.sv ----
// Purpose: Self-checking bench of the PWM timer
// Assumes: Classic Wishbone master, load model on the pins
// Notes:   Random period, edges and prescale from a fixed seed
`timescale 1ns/100ps
`include "pwm_timer_consts.svh"
module multi_output_pwm_timer_test;
   import pwm_timer_pkg::*;
   logic              clk_sys;
   logic              rst_b;
   logic              wb_cyc_i;
   logic              wb_stb_i;
   logic              wb_we_i;
   logic [7:0]        wb_adr_i;
   logic [3:0]        wb_sel_i;
   logic [31:0]       wb_dat_i;
   logic [31:0]       wb_dat_o;
   logic              wb_ack_o;
   logic              irq_o;
   logic [`NUM_OUT:1] pwm_o;
   int                period_len [1:`NUM_OUT];
   int                high_len [1:`NUM_OUT];
   int                failures;
   int                tests_run;
   word_type          rd;
   word_type          rd2;
   int                p, a, b, t, c;
   int                m [2:6];

   pwm_timer u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
      .pwm_o(pwm_o));
   pwm_load_model u_load (.pwm_in(pwm_o), .clk_sys(clk_sys), .rst_b(rst_b),
      .period_ff(period_len), .high_ff(high_len));

   // Clock at 40 MHz
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask

   // One classic cycle; request held until ack is sampled at an edge
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output word_type rdat);
      int n;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (wb_ack_o === 1'b1) break;
      end
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 20) begin
         $display("[FAIL] %0t no acknowledge", $time);
         failures++;
         complete_run();
      end
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      $display("[FAIL] %0t run timed out", $time);
      failures++;
      complete_run();
   end

   initial begin
      rst_b = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0000_0000;
      failures = 0;
      tests_run = 0;
      void'($urandom(32'h0000_54e2));
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      wb_xfer(1'b0, `OFS_CTRL, 32'h0000_0000, rd);
      check(rd, 32'h0000_0002);
      wb_xfer(1'b0, 8'hFC, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      wb_xfer(1'b1, `OFS_PSC_TERM, 32'hFFFF_FFFF, rd);
      wb_xfer(1'b0, `OFS_PSC_TERM, 32'h0000_0000, rd);
      check(rd, 32'hFFFF_FFFF);
      // Out1 single-edge on match1, out2 double-edge on matches 1 and 2
      for (int k = 0; k < 6; k++) begin
         p = 3 + $urandom % 18;
         t = (k == 0) ? 0 : $urandom % 4;
         a = $urandom % p;
         b = $urandom % (p + 1);
         if (b == a) b = (a + 1) % (p + 1);
         wb_xfer(1'b1, `OFS_CTRL, 32'h0000_0002, rd);
         wb_xfer(1'b1, `OFS_PSC_TERM, t, rd);
         wb_xfer(1'b1, `OFS_MATCH_BASE, p, rd);
         wb_xfer(1'b1, `OFS_MATCH_BASE + 8'h04, a, rd);
         wb_xfer(1'b1, `OFS_MATCH_BASE + 8'h08, b, rd);
         wb_xfer(1'b1, `OFS_OUT_CTRL, 32'h0000_0302, rd);
         wb_xfer(1'b1, `OFS_CTRL, 32'h0000_0001, rd);
         repeat (4 * (p + 1) * (t + 1)) @(posedge clk_sys);
         check(period_len[1], (p + 1) * (t + 1));
         check(high_len[1], (a + 1) * (t + 1));
         check(period_len[2], (p + 1) * (t + 1));
         if (a < b) check(high_len[2], (b - a) * (t + 1));
         else check(high_len[2], (p + 1 - a + b) * (t + 1));
      end
      // Interrupt on match0: raise, read-clear, mask
      wb_xfer(1'b1, `OFS_MATCH_CTRL, 32'h0000_0001, rd);
      wb_xfer(1'b1, `OFS_MASK, 32'h0000_0001, rd);
      repeat (2 * (p + 1) * (t + 1)) @(posedge clk_sys);
      check(irq_o, 1'b1);
      wb_xfer(1'b0, `OFS_STATUS, 32'h0000_0000, rd);
      check(rd, 32'h0000_0001);
      wb_xfer(1'b1, `OFS_MASK, 32'h0000_0000, rd);
      repeat (2) @(posedge clk_sys);
      check(irq_o, 1'b0);
      // Reset on match2 sets the cycle to b+1 ticks; match0 is reached only when b equals p,
      // so otherwise only output 2, rising on match1 below match2, still repeats
      if (a > b) begin
         c = a;
         a = b;
         b = c;
      end
      wb_xfer(1'b1, `OFS_MATCH_BASE + 8'h04, a, rd);
      wb_xfer(1'b1, `OFS_MATCH_BASE + 8'h08, b, rd);
      wb_xfer(1'b1, `OFS_MATCH_CTRL, 32'h0000_0080, rd);
      repeat (4 * (p + 1) * (t + 1)) @(posedge clk_sys);
      check(period_len[2], (b + 1) * (t + 1));
      // Stop on match1 clears run and freezes the count
      wb_xfer(1'b1, `OFS_MATCH_CTRL, 32'h0000_0020, rd);
      repeat (2 * (p + 1) * (t + 1)) @(posedge clk_sys);
      wb_xfer(1'b0, `OFS_CTRL, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      wb_xfer(1'b0, `OFS_COUNT, 32'h0000_0000, rd);
      wb_xfer(1'b0, `OFS_COUNT, 32'h0000_0000, rd2);
      check(rd2, rd);
      // All six outputs: out3 double-edge on matches 2 and 3, others single-edge
      wb_xfer(1'b1, `OFS_CTRL, 32'h0000_0002, rd);
      wb_xfer(1'b1, `OFS_MATCH_CTRL, 32'h0000_0000, rd);
      for (int i = 2; i <= 6; i++) begin
         m[i] = $urandom % p;
         if (i == 3 && m[3] == m[2]) m[3] = (m[2] + 1) % p;
         wb_xfer(1'b1, 8'(`OFS_MATCH_BASE + 4 * i), m[i], rd);
      end
      wb_xfer(1'b1, `OFS_OUT_CTRL, 32'h0000_3F04, rd);
      wb_xfer(1'b1, `OFS_CTRL, 32'h0000_0001, rd);
      repeat (4 * (p + 1) * (t + 1)) @(posedge clk_sys);
      check(high_len[2], (m[2] + 1) * (t + 1));
      for (int i = 3; i <= 6; i++) begin
         check(period_len[i], (p + 1) * (t + 1));
      end
      if (m[2] < m[3]) check(high_len[3], (m[3] - m[2]) * (t + 1));
      else check(high_len[3], (p + 1 - m[2] + m[3]) * (t + 1));
      for (int i = 4; i <= 6; i++) begin
         check(high_len[i], (m[i] + 1) * (t + 1));
      end
      complete_run();
   end
endmodule

// ---- testbench/pwm_load_model.sv ----
// Purpose: Load on the PWM pins, measuring period and high time
// Assumes: Outputs change only just after a rising clock edge
// Notes:   Figures are in clock cycles, last complete pulse only
`timescale 1ns/100ps
`include "pwm_timer_consts.svh"
module pwm_load_model
   import pwm_timer_pkg::*;
(
   input  wire logic [`NUM_OUT:1] pwm_in,          // Pins from the timer
   input  wire logic              clk_sys,         // System clock
   input  wire logic              rst_b,           // Async reset, active low
   output int                     period_ff [1:`NUM_OUT], // Rise to rise
   output int                     high_ff [1:`NUM_OUT]    // Rise to fall
);
   logic [`NUM_OUT:1] prev_ff;
   int                age_ff [1:`NUM_OUT];

   // Age restarts on each rise; a purely passive load never loads the pin back
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prev_ff <= '0;
         for (int i = 1; i <= `NUM_OUT; i++) begin
            age_ff[i] <= 0;
            period_ff[i] <= 0;
            high_ff[i] <= 0;
         end
      end else begin
         prev_ff <= pwm_in;
         for (int i = 1; i <= `NUM_OUT; i++) begin
            if (pwm_in[i] && !prev_ff[i]) begin
               period_ff[i] <= age_ff[i];
               age_ff[i] <= 1;
            end else begin
               age_ff[i] <= age_ff[i] + 1;
            end
            if (!pwm_in[i] && prev_ff[i]) begin
               high_ff[i] <= age_ff[i];
            end
         end
      end
   end
endmodule
